// ==== hdl/usw_top.sv ====
// serial port core: apb registers, pin routing, transmitter and receiver
// What this block does
// - single-wire off: shared pin only receives; on: enables pick direction
// - single-wire with both enables high: shared pin only receives
// - single-wire control holds bit 0 only, reset 0, upper bits read zero
// - one data register: write sends, read gives received byte
// - bit rate is clock over 64(N+1), or 16(N+1) at high speed
// - free-running 8-bit baud timer, divisor 0 to 255
// - frames are start, 8 or 9 data bits, one or two stop bits
// - even, odd or no parity from enable and type bits
// - reset format is 8 data bits, no parity, one stop bit
// - data bits go least significant first both ways
// - transmitter and receiver share one format and one baud setting
// - pins serve the port only with module select and enables set
// - transmit line idles high
// - master enable low releases both serial pins
// - disabling empties the data buffers
// - disable clears enables, break, rx flags; sets idle and empty flags
// - disable keeps direction, single-wire and module select bits and the divisor; frame bits take the written value
// - disable aborts frames at once; re-enable keeps configuration
// - with address detect, top data bit marks address or data
// - two-stop choice is transmit only; receiver checks one stop bit
// - parity or address bit takes the top data position
// - word length bit picks 8 or 9 data bits
// - ninth bit received into read-only bit, sent from write-only bit
// - break holds line low at least 13 bits until request clears
// - receive recovery runs at sixteen times the bit rate
`timescale 1ns/100ps
`include "usw_regs.svh"
module usw_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic transmit_pin_out,
  output logic transmit_pin_oe,
  input wire logic shared_serial_pin_in,
  output logic shared_serial_pin_out,
  output logic shared_serial_pin_oe
);
  logic master_en_r, nine_r, par_en_r, par_odd_r, two_stop_r, brk_r, tx9_r, rx9_r;
  logic tx_en_r, rx_en_r, baud_hi_r, addr_en_r, swm_r, async_sel_r;
  logic [3:0] dir_low_r;
  logic [7:0] divisor_r;
  logic [7:0] tx_buf_r;
  logic tx_full_r, tx_idle_r;
  logic [7:0] rx_buf_r;
  logic rx_avail_r, ovr_r, ferr_r, perr_r, nf_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  usw_pkg::usw_tx_state_type tx_st_r;
  usw_pkg::usw_rx_state_type rx_st_r;
  logic [3:0] tx_cnt_r, tx_ph_r, rx_cnt_r, rx_ph_r;
  logic [8:0] tx_sh_r, rx_sh_r;
  logic tx_line_r, rx_noise_r;
  logic tick16, rx_level, rx_noisy, tx_tick, rx_mid, rx_done, rx_keep;
  logic wr, rd, setup, disable_evt, data_wr, data_rd, port_on, tx_run, rx_run;
  logic tx_on_shared, tx_on_own, rx_route, rx_pin;
  logic [3:0] last_bit, nstop;
  logic tx_bit;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `USW_ADDR_FRAME) || (a == `USW_ADDR_DIR) || (a == `USW_ADDR_SWIRE) ||
                (a == `USW_ADDR_DATA) || (a == `USW_ADDR_BAUD) || (a == `USW_ADDR_STATUS) ||
                (a == `USW_ADDR_MODSEL);
  endfunction : is_mapped

  // parity over the n low bits, odd type inverts
  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    parity_of = p;
  endfunction : parity_of

  // apb: zero wait states, frozen with the clock enable
  assign pready = ce;
  assign setup = ce && psel && !penable;
  assign wr = ce && psel && penable && pwrite;
  assign rd = ce && psel && penable && !pwrite;
  assign data_wr = wr && (paddr == `USW_ADDR_DATA);
  assign data_rd = rd && (paddr == `USW_ADDR_DATA);
  assign disable_evt = wr && (paddr == `USW_ADDR_FRAME) && !pwdata[`USW_FC_MASTER] && master_en_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // one format for both directions; parity or address bit sits in the top slot
  assign last_bit = (nine_r ? `USW_BITS_NINE : `USW_BITS_EIGHT) - `USW_PH_ONE;
  assign nstop = two_stop_r ? `USW_STOP_TWO : `USW_STOP_ONE;

  // pin routing
  assign port_on = async_sel_r && master_en_r;
  assign tx_on_shared = port_on && swm_r && tx_en_r && !rx_en_r;
  assign tx_on_own = port_on && tx_en_r && !swm_r;
  assign rx_route = port_on && rx_en_r;
  assign transmit_pin_oe = tx_on_own;
  assign transmit_pin_out = tx_line_r;
  assign shared_serial_pin_oe = tx_on_shared;
  assign shared_serial_pin_out = tx_line_r;
  // an unrouted receiver sees an idle line
  assign rx_pin = rx_route ? shared_serial_pin_in : 1'b1;
  assign tx_run = master_en_r && tx_en_r && (tx_on_own || tx_on_shared);
  assign rx_run = rx_route && !tx_on_shared;

  usw_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .divisor(divisor_r),
    .high_speed(baud_hi_r),
    .tick16(tick16)
  );

  usw_rx_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_in(rx_pin),
    .tick16(tick16),
    .level(rx_level),
    .noisy(rx_noisy)
  );

  // frame control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_en_r <= 1'b0;
      nine_r <= 1'b0;
      par_en_r <= 1'b0;
      par_odd_r <= 1'b0;
      two_stop_r <= 1'b0;
      brk_r <= 1'b0;
      tx9_r <= 1'b0;
    end else if (wr && paddr == `USW_ADDR_FRAME) begin
      master_en_r <= pwdata[`USW_FC_MASTER];
      nine_r <= pwdata[`USW_FC_NINE];
      par_en_r <= pwdata[`USW_FC_PAR_EN];
      par_odd_r <= pwdata[`USW_FC_PAR_ODD];
      two_stop_r <= pwdata[`USW_FC_TWO_STOP];
      brk_r <= pwdata[`USW_FC_BREAK] && !disable_evt;
      tx9_r <= pwdata[`USW_FC_TX9];
    end
  end

  // direction control; other bits survive a disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      baud_hi_r <= 1'b0;
      addr_en_r <= 1'b0;
      dir_low_r <= `USW_RST_LOW4;
    end else if (ce) begin
      if (wr && paddr == `USW_ADDR_DIR) begin
        tx_en_r <= pwdata[`USW_DC_TX_EN];
        rx_en_r <= pwdata[`USW_DC_RX_EN];
        baud_hi_r <= pwdata[`USW_DC_BAUD_HI];
        addr_en_r <= pwdata[`USW_DC_ADDR_EN];
        dir_low_r <= pwdata[3:0];
      end else if (disable_evt) begin
        tx_en_r <= 1'b0;
        rx_en_r <= 1'b0;
      end
    end
  end

  // single-wire, module select and divisor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swm_r <= 1'b0;
      async_sel_r <= 1'b0;
      divisor_r <= `USW_RST_BYTE;
    end else begin
      if (wr && paddr == `USW_ADDR_SWIRE) begin
        swm_r <= pwdata[`USW_SW_ENABLE];
      end
      if (wr && paddr == `USW_ADDR_MODSEL) begin
        async_sel_r <= pwdata[`USW_MS_ASYNC];
      end
      if (wr && paddr == `USW_ADDR_BAUD) begin
        divisor_r <= pwdata[7:0];
      end
    end
  end

  // read data captured in the setup cycle, answered in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= !is_mapped(paddr);
      prdata_r <= 32'h0000_0000;
      if (paddr == `USW_ADDR_FRAME) begin
        prdata_r[7:0] <= {master_en_r, nine_r, par_en_r, par_odd_r, two_stop_r, brk_r, rx9_r, 1'b0};
      end else if (paddr == `USW_ADDR_DIR) begin
        prdata_r[7:0] <= {tx_en_r, rx_en_r, baud_hi_r, addr_en_r, dir_low_r};
      end else if (paddr == `USW_ADDR_SWIRE) begin
        prdata_r[`USW_SW_ENABLE] <= swm_r;
      end else if (paddr == `USW_ADDR_DATA) begin
        prdata_r[7:0] <= rx_buf_r;
      end else if (paddr == `USW_ADDR_BAUD) begin
        prdata_r[7:0] <= divisor_r;
      end else if (paddr == `USW_ADDR_STATUS) begin
        prdata_r[7:0] <= {perr_r, nf_r, ferr_r, ovr_r, rx_st_r == usw_pkg::RX_IDLE, rx_avail_r, tx_idle_r, !tx_full_r};
      end else if (paddr == `USW_ADDR_MODSEL) begin
        prdata_r[`USW_MS_ASYNC] <= async_sel_r;
      end
    end
  end

  // transmit buffer: writes while full are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_r <= `USW_RST_BYTE;
      tx_full_r <= 1'b0;
    end else if (ce) begin
      if (!master_en_r || disable_evt) begin
        tx_full_r <= 1'b0;
      end else if (data_wr && !tx_full_r) begin
        tx_buf_r <= pwdata[7:0];
        tx_full_r <= 1'b1;
      end else if (tx_tick && tx_full_r && (tx_st_r == usw_pkg::TX_IDLE ||
                   (tx_st_r == usw_pkg::TX_STOP && tx_cnt_r == nstop))) begin
        tx_full_r <= 1'b0;
      end
    end
  end

  // transmit idle: frame end sets, data write clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_idle_r <= 1'b1;
    end else if (ce) begin
      if (!master_en_r || disable_evt) begin
        tx_idle_r <= 1'b1;
      end else if (tx_tick && tx_st_r == usw_pkg::TX_STOP && tx_cnt_r == nstop) begin
        tx_idle_r <= 1'b1;
      end else if (data_wr) begin
        tx_idle_r <= 1'b0;
      end
    end
  end

  // transmitter bit phase, one bit every sixteen oversampling ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ph_r <= `USW_RST_CNT;
    end else if (tick16) begin
      tx_ph_r <= tx_ph_r + `USW_PH_ONE;
    end
  end
  assign tx_tick = tick16 && (tx_ph_r == `USW_PH_LAST);
  assign tx_bit = (par_en_r && tx_cnt_r == last_bit) ? parity_of(tx_sh_r, last_bit, par_odd_r)
                                                     : tx_sh_r[tx_cnt_r];

  // transmitter: each tick puts the next bit on the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= usw_pkg::TX_IDLE;
      tx_line_r <= 1'b1;
      tx_cnt_r <= `USW_RST_CNT;
      tx_sh_r <= `USW_RST_DATA;
    end else if (ce) begin
      if (!tx_run) begin
        tx_st_r <= usw_pkg::TX_IDLE;
        tx_line_r <= 1'b1;
      end else if (tx_tick) begin
        case (tx_st_r)
          usw_pkg::TX_IDLE: begin
            tx_cnt_r <= `USW_RST_CNT;
            if (tx_full_r) begin
              tx_sh_r <= {tx9_r, tx_buf_r};
              tx_line_r <= 1'b0;
              tx_st_r <= usw_pkg::TX_DATA;
            end else if (brk_r && tx_idle_r) begin
              tx_line_r <= 1'b0;
              tx_st_r <= usw_pkg::TX_BREAK;
            end else begin
              tx_line_r <= 1'b1;
            end
          end
          usw_pkg::TX_DATA: begin
            tx_line_r <= tx_bit;
            if (tx_cnt_r == last_bit) begin
              tx_cnt_r <= `USW_RST_CNT;
              tx_st_r <= usw_pkg::TX_STOP;
            end else begin
              tx_cnt_r <= tx_cnt_r + `USW_PH_ONE;
            end
          end
          usw_pkg::TX_STOP: begin
            if (tx_cnt_r == nstop && tx_full_r) begin
              tx_sh_r <= {tx9_r, tx_buf_r};
              tx_line_r <= 1'b0;
              tx_cnt_r <= `USW_RST_CNT;
              tx_st_r <= usw_pkg::TX_DATA;
            end else if (tx_cnt_r == nstop) begin
              tx_line_r <= 1'b1;
              tx_st_r <= usw_pkg::TX_IDLE;
            end else begin
              tx_line_r <= 1'b1;
              tx_cnt_r <= tx_cnt_r + `USW_PH_ONE;
            end
          end
          usw_pkg::TX_BREAK: begin
            if (tx_cnt_r == `USW_BREAK_BITS && !brk_r) begin
              tx_line_r <= 1'b1;
              tx_cnt_r <= `USW_PH_ONE;
              tx_st_r <= usw_pkg::TX_STOP;
            end else if (tx_cnt_r == `USW_BREAK_BITS) begin
              tx_cnt_r <= `USW_PH_ONE;
            end else begin
              tx_line_r <= 1'b0;
              tx_cnt_r <= tx_cnt_r + `USW_PH_ONE;
            end
          end
          default: begin
            tx_st_r <= usw_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  assign rx_mid = tick16 && (rx_ph_r == `USW_PH_MID);

  // receiver: start found on oversampling ticks, bits taken mid-cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= usw_pkg::RX_IDLE;
      rx_ph_r <= `USW_RST_CNT;
      rx_cnt_r <= `USW_RST_CNT;
      rx_noise_r <= 1'b0;
    end else if (ce) begin
      if (!rx_run) begin
        rx_st_r <= usw_pkg::RX_IDLE;
      end else if (tick16) begin
        rx_ph_r <= rx_ph_r + `USW_PH_ONE;
        case (rx_st_r)
          usw_pkg::RX_IDLE: begin
            if (!rx_level) begin
              rx_ph_r <= `USW_PH_ONE;
              rx_noise_r <= 1'b0;
              rx_st_r <= usw_pkg::RX_START;
            end
          end
          usw_pkg::RX_START: begin
            if (rx_mid) begin
              rx_cnt_r <= `USW_RST_CNT;
              rx_noise_r <= rx_noisy;
              rx_st_r <= rx_level ? usw_pkg::RX_IDLE : usw_pkg::RX_BITS;
            end
          end
          usw_pkg::RX_BITS: begin
            if (rx_mid) begin
              rx_noise_r <= rx_noise_r | rx_noisy;
              if (rx_cnt_r == last_bit) begin
                rx_st_r <= usw_pkg::RX_STOP;
              end else begin
                rx_cnt_r <= rx_cnt_r + `USW_PH_ONE;
              end
            end
          end
          usw_pkg::RX_STOP: begin
            if (rx_mid) begin
              rx_st_r <= usw_pkg::RX_IDLE;
            end
          end
          default: begin
            rx_st_r <= usw_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // receive shift cells, least significant bit arrives first
  for (genvar i = 0; i < 9; i++) begin : g_rx_cell
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_sh_r[i] <= 1'b0;
      end else if (ce && rx_run && rx_st_r == usw_pkg::RX_BITS && rx_mid && rx_cnt_r == 4'(i)) begin
        rx_sh_r[i] <= rx_level;
      end
    end
  end

  assign rx_done = ce && rx_run && rx_st_r == usw_pkg::RX_STOP && rx_mid;
  // address detect drops frames whose top bit is low
  assign rx_keep = !addr_en_r || rx_sh_r[last_bit];

  // receive buffer and flags: a read clears them, a new frame wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_r <= `USW_RST_BYTE;
      rx9_r <= 1'b0;
      rx_avail_r <= 1'b0;
      ovr_r <= 1'b0;
      ferr_r <= 1'b0;
      perr_r <= 1'b0;
      nf_r <= 1'b0;
    end else if (ce) begin
      if (!master_en_r || disable_evt) begin
        rx_avail_r <= 1'b0;
        ovr_r <= 1'b0;
        ferr_r <= 1'b0;
        perr_r <= 1'b0;
        nf_r <= 1'b0;
      end else begin
        if (data_rd) begin
          rx_avail_r <= 1'b0;
          ovr_r <= 1'b0;
          ferr_r <= 1'b0;
          perr_r <= 1'b0;
          nf_r <= 1'b0;
        end
        if (rx_done && rx_keep && rx_avail_r && !data_rd) begin
          ovr_r <= 1'b1;
        end else if (rx_done && rx_keep) begin
          rx_buf_r <= rx_sh_r[7:0];
          rx9_r <= nine_r && rx_sh_r[8];
          rx_avail_r <= 1'b1;
          ferr_r <= !rx_level;
          perr_r <= par_en_r && (parity_of(rx_sh_r, last_bit, par_odd_r) != rx_sh_r[last_bit]);
          nf_r <= rx_noise_r;
        end
      end
    end
  end
endmodule : usw_top

// ==== shared/usw_regs.svh ====
// register offsets, bit positions, reset values and timing counts of the serial port
`ifndef USW_REGS_SVH
`define USW_REGS_SVH

`define USW_ADDR_FRAME 8'h00
`define USW_ADDR_DIR 8'h04
`define USW_ADDR_SWIRE 8'h08
`define USW_ADDR_DATA 8'h0C
`define USW_ADDR_BAUD 8'h10
`define USW_ADDR_STATUS 8'h14
`define USW_ADDR_MODSEL 8'h18

`define USW_FC_MASTER 7
`define USW_FC_NINE 6
`define USW_FC_PAR_EN 5
`define USW_FC_PAR_ODD 4
`define USW_FC_TWO_STOP 3
`define USW_FC_BREAK 2
`define USW_FC_RX9 1
`define USW_FC_TX9 0

`define USW_DC_TX_EN 7
`define USW_DC_RX_EN 6
`define USW_DC_BAUD_HI 5
`define USW_DC_ADDR_EN 4

`define USW_SW_ENABLE 0
`define USW_MS_ASYNC 0

`define USW_ST_PERR 7
`define USW_ST_NOISE 6
`define USW_ST_FERR 5
`define USW_ST_OVR 4
`define USW_ST_RX_IDLE 3
`define USW_ST_RX_AVAIL 2
`define USW_ST_TX_IDLE 1
`define USW_ST_TX_EMPTY 0

`define USW_RST_BYTE 8'h00
`define USW_RST_LOW4 4'h0
`define USW_RST_DATA 9'h000
`define USW_RST_CNT 4'h0
`define USW_PH_LAST 4'hF
`define USW_PH_MID 4'h7
`define USW_PH_ONE 4'h1
`define USW_BITS_EIGHT 4'h8
`define USW_BITS_NINE 4'h9
`define USW_BREAK_BITS 4'hD
`define USW_STOP_ONE 4'h1
`define USW_STOP_TWO 4'h2
`define USW_LOW_PRESCALE 2'h3
`define USW_PRE_RST 2'h0
`define USW_PRE_ONE 2'h1
`define USW_TIMER_ONE 8'h01

`endif

// ==== shared/usw_pkg.sv ====
// state types of the serial port
package usw_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_STOP, TX_BREAK} usw_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} usw_rx_state_type;
endpackage : usw_pkg

// ==== hdl/usw_baud.sv ====
// baud timer giving a tick at sixteen times the bit rate
`timescale 1ns/100ps
`include "usw_regs.svh"
module usw_baud (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] divisor,
  input wire logic high_speed,
  output logic tick16
);
  logic [7:0] timer_r;
  logic [1:0] pre_r;
  logic period_end;

  assign period_end = (timer_r == `USW_RST_BYTE);
  // low speed inserts a divide by four: 64 = 16 x 4
  assign tick16 = ce && period_end && (high_speed || pre_r == `USW_LOW_PRESCALE);

  // free running, reloads the live divisor each period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_r <= `USW_RST_BYTE;
    end else if (ce) begin
      if (period_end) begin
        timer_r <= divisor;
      end else begin
        timer_r <= timer_r - `USW_TIMER_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= `USW_PRE_RST;
    end else if (ce && period_end) begin
      pre_r <= high_speed ? `USW_PRE_RST : pre_r + `USW_PRE_ONE;
    end
  end
endmodule : usw_baud

// ==== hdl/usw_rx_filter.sv ====
// pin synchroniser and three-sample majority filter for the receive line
`timescale 1ns/100ps
module usw_rx_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic pin_in,
  input wire logic tick16,
  output logic level,
  output logic noisy
);
  logic sync1_r;
  logic sync2_r;
  logic [2:0] hist_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else if (ce) begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // samples taken at the oversampling rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_r <= 3'h7;
    end else if (tick16) begin
      hist_r <= {hist_r[1:0], sync2_r};
    end
  end

  assign level = (hist_r[0] & hist_r[1]) | (hist_r[1] & hist_r[2]) | (hist_r[0] & hist_r[2]);
  assign noisy = !((hist_r == 3'h7) || (hist_r == 3'h0));
endmodule : usw_rx_filter

// ==== bench/usw_assertions.sv ====
// checker of pin routing, apb answers and bit timing
`timescale 1ns/100ps
`include "usw_regs.svh"
module usw_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic transmit_pin_out,
  input wire logic transmit_pin_oe,
  input wire logic shared_serial_pin_in,
  input wire logic shared_serial_pin_out,
  input wire logic shared_serial_pin_oe
);
  logic mst_r, txe_r, rxe_r, sw_r, ms_r, wr_c, unm_c;
  assign wr_c = psel & penable & pwrite & ce;
  assign unm_c = (paddr > `USW_ADDR_MODSEL) || (paddr[1:0] != 2'h0);
  // shadow of the routing bits, written at the apb commit edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mst_r, txe_r, rxe_r, sw_r, ms_r} <= 5'h00;
    end else if (wr_c && paddr == `USW_ADDR_FRAME) begin
      mst_r <= pwdata[`USW_FC_MASTER];
      if (mst_r && !pwdata[`USW_FC_MASTER]) begin
        txe_r <= 1'b0;
        rxe_r <= 1'b0;
      end
    end else if (wr_c && paddr == `USW_ADDR_DIR) begin
      txe_r <= pwdata[`USW_DC_TX_EN];
      rxe_r <= pwdata[`USW_DC_RX_EN];
    end else if (wr_c && paddr == `USW_ADDR_SWIRE) begin
      sw_r <= pwdata[`USW_SW_ENABLE];
    end else if (wr_c && paddr == `USW_ADDR_MODSEL) begin
      ms_r <= pwdata[`USW_MS_ASYNC];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_tx_oe; transmit_pin_oe == (ms_r & mst_r & txe_r & !sw_r); endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("transmit pin enable wrong");
  property p_sw_oe; shared_serial_pin_oe == (ms_r & mst_r & sw_r & txe_r & !rxe_r); endproperty
  a_sw_oe: assert property (p_sw_oe) else $error("shared pin enable wrong");
  property p_rx_only; !sw_r |-> !shared_serial_pin_oe; endproperty
  a_rx_only: assert property (p_rx_only) else $error("shared pin driven outside single wire");
  property p_release; $fell(mst_r) |-> !transmit_pin_oe && !shared_serial_pin_oe; endproperty
  a_release: assert property (p_release) else $error("pins kept after disable");
  property p_upper; psel && penable && paddr == `USW_ADDR_SWIRE |-> prdata[31:1] == 31'h00000000; endproperty
  a_upper: assert property (p_upper) else $error("single wire upper bits not zero");
  property p_slverr; psel && penable |-> pslverr == unm_c; endproperty
  a_slverr: assert property (p_slverr) else $error("error response wrong");
  property p_bit;
    $changed(transmit_pin_out) && transmit_pin_oe |=> (!transmit_pin_oe || $stable(transmit_pin_out))[*8];
  endproperty
  a_bit: assert property (p_bit) else $error("bit cell shorter than minimum");
  property p_idle; $rose(transmit_pin_oe) |-> transmit_pin_out; endproperty
  a_idle: assert property (p_idle) else $error("line not idle high at enable");
endmodule : usw_checker

// ==== bench/usw_remote.sv ====
// remote serial transceiver on the far side of the line
`timescale 1ns/100ps
module usw_remote (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (bt) @(posedge pclk);
    end
  endtask : send
  // start bit length is measured, so the first data bit must be 1
  task automatic recv(output logic [7:0] b, output int len, input int bt);
    len = 0;
    while (line_in !== 1'b0) @(posedge pclk);
    while (line_in === 1'b0) begin
      len++;
      @(posedge pclk);
    end
    repeat (bt / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      b[i] = line_in;
      repeat (bt) @(posedge pclk);
    end
  endtask : recv
endmodule : usw_remote

// ==== bench/tb_uart_single_wire_baud_format.sv ====
// top testbench of the serial port core
`timescale 1ns/100ps
`include "usw_regs.svh"
bind usw_top usw_checker usw_checker_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .transmit_pin_out(transmit_pin_out), .transmit_pin_oe(transmit_pin_oe),
  .shared_serial_pin_in(shared_serial_pin_in), .shared_serial_pin_out(shared_serial_pin_out),
  .shared_serial_pin_oe(shared_serial_pin_oe));
module tb_uart_single_wire_baud_format;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, w, rem_line, tx_wire;
  logic transmit_pin_out, transmit_pin_oe, shared_serial_pin_in, shared_serial_pin_out, shared_serial_pin_oe;
  logic [7:0] paddr, a, d, e, b;
  logic [31:0] pwdata, prdata, rd;
  int total_checks = 0;
  int n_mismatch = 0;
  int len;
  // write flag, address, write data, expected read
  localparam logic [24:0] ROWS [0:9] = '{
    {1'h0, `USW_ADDR_FRAME, 8'h00, 8'h00}, {1'h0, `USW_ADDR_DIR, 8'h00, 8'h00},
    {1'h0, `USW_ADDR_SWIRE, 8'h00, 8'h00}, {1'h0, `USW_ADDR_STATUS, 8'h00, 8'h0B},
    {1'h1, `USW_ADDR_SWIRE, 8'hFF, 8'h01}, {1'h1, `USW_ADDR_BAUD, 8'hA5, 8'hA5},
    {1'h1, `USW_ADDR_DIR, 8'h2F, 8'h2F}, {1'h1, `USW_ADDR_FRAME, 8'h78, 8'h78},
    {1'h1, `USW_ADDR_SWIRE, 8'h00, 8'h00}, {1'h1, 8'h1C, 8'h55, 8'h00}};
  // a released transmit line floats up to its pull-up
  assign tx_wire = transmit_pin_oe ? transmit_pin_out : 1'b1;
  assign shared_serial_pin_in = shared_serial_pin_oe ? shared_serial_pin_out : rem_line;
  usw_top usw_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmit_pin_out(transmit_pin_out), .transmit_pin_oe(transmit_pin_oe),
    .shared_serial_pin_in(shared_serial_pin_in), .shared_serial_pin_out(shared_serial_pin_out),
    .shared_serial_pin_oe(shared_serial_pin_oe));
  usw_remote usw_remote_i (.pclk(pclk), .line_in(tx_wire), .line_out(rem_line));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    total_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] dat, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
    @(negedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
    logic [31:0] q;
    apb(1'b1, ad, dat, q);
  endtask : wr
  task automatic wait_st(input int n, input logic v);
    do apb(1'b0, `USW_ADDR_STATUS, 32'h00000000, rd); while (rd[n] !== v);
  endtask : wait_st
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // about 6000 cycles are needed; cut a hang well after that
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    $display("BAD watchdog expired");
    end_sim();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      {w, a, d, e} = ROWS[i];
      apb(w, a, {24'h000000, d}, rd);
      apb(1'b0, a, 32'h00000000, rd);
      chk("register", {24'h000000, e}, rd);
    end
    $display("register table done");
    wr(`USW_ADDR_MODSEL, 32'h00000001);
    wr(`USW_ADDR_BAUD, 32'h00000001);
    wr(`USW_ADDR_DIR, 32'h000000C5);
    wr(`USW_ADDR_FRAME, 32'h00000080);
    fork
      usw_remote_i.recv(b, len, 128);
      wr(`USW_ADDR_DATA, 32'h000000A3);
    join
    chk("tx byte", 32'h000000A3, {24'h000000, b});
    chk("start bit clocks", 32'h00000080, len);
    for (int p = 0; p < 2; p++) begin
      wait_st(`USW_ST_TX_IDLE, 1'b1);
      chk("idle line", 32'h00000001, {31'h00000000, tx_wire});
      wr(`USW_ADDR_FRAME, 32'h000000A0 | (p << 4));
      fork
        usw_remote_i.recv(b, len, 128);
        wr(`USW_ADDR_DATA, 32'h00000007);
      join
      chk("parity frame", {24'h000000, ~p[0], 7'h07}, {24'h000000, b});
    end
    $display("transmit done");
    wait_st(`USW_ST_TX_IDLE, 1'b1);
    wr(`USW_ADDR_FRAME, 32'h00000080);
    usw_remote_i.send(8'h5A, 128);
    wait_st(`USW_ST_RX_AVAIL, 1'b1);
    apb(1'b0, `USW_ADDR_DATA, 32'h00000000, rd);
    chk("rx byte", 32'h0000005A, rd);
    $display("receive done");
    wr(`USW_ADDR_DATA, 32'h00000081);
    while (transmit_pin_out !== 1'b0) @(posedge pclk);
    wr(`USW_ADDR_FRAME, 32'h00000000);
    chk("tx enable", 32'h00000000, {31'h00000000, transmit_pin_oe});
    apb(1'b0, `USW_ADDR_DIR, 32'h00000000, rd);
    chk("dir after off", 32'h00000005, rd);
    apb(1'b0, `USW_ADDR_BAUD, 32'h00000000, rd);
    chk("divisor after off", 32'h00000001, rd);
    apb(1'b0, `USW_ADDR_STATUS, 32'h00000000, rd);
    chk("status after off", 32'h0000000B, rd);
    wr(`USW_ADDR_FRAME, 32'h00000080);
    wr(`USW_ADDR_DIR, 32'h000000C5);
    apb(1'b0, `USW_ADDR_STATUS, 32'h00000000, rd);
    chk("status after on", 32'h0000000B, rd);
    chk("line after on", 32'h00000001, {31'h00000000, tx_wire});
    $display("disable done");
    end_sim();
  end
endmodule : tb_uart_single_wire_baud_format
